// ### core/supervisor_reset_generator.sv
// supervisory reset generator with manual reset and watchdog
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_generator #(
  parameter longint unsigned HOLD_CYCLES = supervisor_pkg::HOLD_CYCLES,
  parameter longint unsigned DOG_CYCLES  = supervisor_pkg::DOG_CYCLES
) (
  // clock and reset
  input  wire logic SYS_CLK_IN,
  input  wire logic RST_IN,
  // monitored inputs, all asynchronous pins
  input  wire logic SUPPLY_LOW_IN,
  input  wire logic MANUAL_RESET_N_IN,
  input  wire logic MANUAL_RESET_DRIVEN_IN,
  input  wire logic WATCHDOG_KICK_IN,
  input  wire logic WATCHDOG_KICK_DRIVEN_IN,
  // reset outputs
  output logic      RESET_N_OUT,
  output logic      RESET_OUT
);
  localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);
  localparam logic [31:0] DOG_LAST  = 32'(DOG_CYCLES - 1);

  logic supply_low;
  logic mr_pin;
  logic mr_driven;
  logic kick;
  logic kick_driven;
  logic kick_prev;
  logic next_kick_prev;
  logic manual_active;
  logic kick_edge;
  logic dog_enabled;
  logic dog_expire;
  logic force_hold;
  supervisor_pkg::sup_state_t state;
  supervisor_pkg::sup_state_t next_state;
  logic [31:0] hold_cnt;
  logic [31:0] next_hold_cnt;
  logic [31:0] dog_cnt;
  logic [31:0] next_dog_cnt;

  // each pin passes two flops before use; 25 ns clock samples 50 ns kicks
  sync2 #(.RESET_VALUE(1'b1)) u_sync_supply (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .d_in   (SUPPLY_LOW_IN),
    .q_out  (supply_low)
  );
  sync2 #(.RESET_VALUE(1'b1)) u_sync_mr (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .d_in   (MANUAL_RESET_N_IN),
    .q_out  (mr_pin)
  );
  sync2 #(.RESET_VALUE(1'b0)) u_sync_mr_drv (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .d_in   (MANUAL_RESET_DRIVEN_IN),
    .q_out  (mr_driven)
  );
  sync2 #(.RESET_VALUE(1'b0)) u_sync_kick (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .d_in   (WATCHDOG_KICK_IN),
    .q_out  (kick)
  );
  sync2 #(.RESET_VALUE(1'b0)) u_sync_kick_drv (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .d_in   (WATCHDOG_KICK_DRIVEN_IN),
    .q_out  (kick_driven)
  );

  always_comb
  begin
    // an undriven pin floats to the pull-up level
    manual_active  = mr_driven & ~mr_pin;
    dog_enabled    = kick_driven;
    next_kick_prev = kick;
    kick_edge      = kick ^ kick_prev;
    // an edge on the last count means the level did not stay too long
    dog_expire     = dog_enabled && !kick_edge
                     && (dog_cnt == DOG_LAST);
    // bouncing switch keeps reloading the hold timer
    force_hold     = supply_low | manual_active;
  end

  always_comb
  begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    case (state)
      supervisor_pkg::ST_HOLD:
      begin
        if (force_hold)
          next_hold_cnt = supervisor_pkg::CNT_ZERO;
        else if (hold_cnt == HOLD_LAST)
        begin
          next_state    = supervisor_pkg::ST_RUN;
          next_hold_cnt = supervisor_pkg::CNT_ZERO;
        end
        else
          next_hold_cnt = hold_cnt + supervisor_pkg::CNT_ONE;
      end
      supervisor_pkg::ST_RUN:
      begin
        if (force_hold || dog_expire)
        begin
          next_state    = supervisor_pkg::ST_HOLD;
          next_hold_cnt = supervisor_pkg::CNT_ZERO;
        end
      end
      default:
      begin
        next_state    = supervisor_pkg::ST_HOLD;
        next_hold_cnt = supervisor_pkg::CNT_ZERO;
      end
    endcase
  end

  always_comb
  begin
    // counter frozen at zero while reset is out, or when disabled
    if (state != supervisor_pkg::ST_RUN || !dog_enabled)
      next_dog_cnt = supervisor_pkg::CNT_ZERO;
    else if (kick_edge || dog_expire)
      next_dog_cnt = supervisor_pkg::CNT_ZERO;
    else
      next_dog_cnt = dog_cnt + supervisor_pkg::CNT_ONE;
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state     <= supervisor_pkg::ST_HOLD;
      hold_cnt  <= supervisor_pkg::CNT_ZERO;
      dog_cnt   <= supervisor_pkg::CNT_ZERO;
      kick_prev <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      hold_cnt  <= next_hold_cnt;
      dog_cnt   <= next_dog_cnt;
      kick_prev <= next_kick_prev;
    end
  end

  // both outputs decoded from the state register, so never out of step
  assign RESET_N_OUT = (state == supervisor_pkg::ST_RUN);
  assign RESET_OUT   = (state != supervisor_pkg::ST_RUN);

  inverse_out_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    RESET_OUT == !RESET_N_OUT)
    else $error("complementary reset outputs disagree");

  hold_on_low_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    force_hold |=> !RESET_N_OUT)
    else $error("reset released while a source is active");

  full_hold_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(RESET_N_OUT) |-> hold_cnt == supervisor_pkg::CNT_ZERO
      && $past(hold_cnt) == HOLD_LAST)
    else $error("reset released before full hold");

  hold_restart_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    supply_low |=> hold_cnt == supervisor_pkg::CNT_ZERO)
    else $error("hold timer not restarted by low supply");

  trigger_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    (RESET_N_OUT && (force_hold || dog_expire)) |=> !RESET_N_OUT)
    else $error("reset source did not assert reset");

  dog_cleared_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    !RESET_N_OUT |=> dog_cnt == supervisor_pkg::CNT_ZERO)
    else $error("watchdog counted during reset");

  kick_clear_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    kick_edge |=> dog_cnt == supervisor_pkg::CNT_ZERO)
    else $error("kick edge did not clear watchdog");

  dog_off_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    !dog_enabled |-> !dog_expire ##1 dog_cnt == supervisor_pkg::CNT_ZERO)
    else $error("disabled watchdog is counting");

  dog_fire_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    dog_expire |=> !RESET_N_OUT ##1 !RESET_N_OUT)
    else $error("watchdog expiry did not reset");

  release_c: cover property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN) $rose(RESET_N_OUT));
  dog_fire_c: cover property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN) dog_expire);
  manual_c: cover property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    RESET_N_OUT ##1 manual_active);
  kick_c: cover property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN) RESET_N_OUT && kick_edge);
endmodule // supervisor_reset_generator
`default_nettype wire

// ### core/supervisor_pkg.sv
// constants for the supervisory reset generator
`default_nettype none
package supervisor_pkg;
  // reference clock
  localparam int unsigned CLK_HZ = 40000000;
  // reset hold period, in ms as printed
  localparam int unsigned HOLD_MS = 200;
  localparam longint unsigned HOLD_CYCLES = (longint'(HOLD_MS) * CLK_HZ) / 1000;
  // watchdog timeout, in ms (1.6 s)
  localparam int unsigned DOG_MS = 1600;
  localparam longint unsigned DOG_CYCLES = (longint'(DOG_MS) * CLK_HZ) / 1000;
  // shortest kick pulse that must be seen, in ns
  localparam int unsigned KICK_MIN_NS = 50;
  localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
  localparam int unsigned KICK_MIN_CYCLES =
    (KICK_MIN_NS / CLK_NS) < 1 ? 1 : (KICK_MIN_NS / CLK_NS);
  // counter width, enough for the longest count
  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  typedef enum logic [0:0] {
    ST_HOLD = 1'b0,
    ST_RUN  = 1'b1
  } sup_state_t;
endpackage
`default_nettype wire

// ### core/sync2.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter logic RESET_VALUE = 1'b1
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic first;
  logic next_first;
  logic next_q;

  always_comb
  begin
    next_first = d_in;
    next_q     = first;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      first <= RESET_VALUE;
      q_out <= RESET_VALUE;
    end
    else
    begin
      first <= next_first;
      q_out <= next_q;
    end
  end
endmodule // sync2
`default_nettype wire

// ### tb/cpu_model.sv
// processor model that toggles the watchdog pin while running
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
  parameter int GAP = 10
) (
  // clock and reset seen by the processor
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // bench control: low stalls the firmware, high pulse selects short kicks
  input  wire logic run_in,
  input  wire logic pulse_in,
  // watchdog pin
  output logic      kick_out
);
  int gap = 0;
  initial kick_out = 1'b0;
  // firmware only runs out of reset, so no kicks while held
  always @(posedge clk_in)
  begin
    if (!reset_n_in || !run_in)
      gap <= 0;
    else if (gap == GAP - 1)
    begin
      gap <= 0;
      kick_out <= ~kick_out;
    end
    else
    begin
      gap <= gap + 1;
      // short mode: the kick falls two cycles (50 ns) after it rose
      if (pulse_in && gap == 1 && kick_out)
        kick_out <= 1'b0;
    end
  end
endmodule // cpu_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the supervisory reset generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int HOLD = 20;
  localparam int DOG = 50;
  logic clk = 1'b0, rst = 1'b1, sup = 1'b0, mr_n = 1'b1, mr_drv = 1'b1;
  logic kick, kick_drv = 1'b1, run = 1'b1, pulse = 1'b0, rn, r;
  int n_fail = 0, n_compared = 0, n;

  supervisor_reset_generator #(.HOLD_CYCLES(HOLD), .DOG_CYCLES(DOG)) uut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .SUPPLY_LOW_IN(sup),
    .MANUAL_RESET_N_IN(mr_n), .MANUAL_RESET_DRIVEN_IN(mr_drv),
    .WATCHDOG_KICK_IN(kick), .WATCHDOG_KICK_DRIVEN_IN(kick_drv),
    .RESET_N_OUT(rn), .RESET_OUT(r));
  cpu_model cpu (.clk_in(clk), .reset_n_in(rn), .run_in(run),
    .pulse_in(pulse), .kick_out(kick));

  initial forever #12.5 clk = ~clk;

  task automatic check(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // counts edges until the reset output reaches lvl
  task automatic wait_lvl(input logic lvl, output int c);
    c = 0;
    while (rn !== lvl && c < 1000)
    begin
      @(posedge clk);
      #1;
      check(r, ~rn);
      c++;
    end
  endtask

  task automatic quiet(input int c);
    repeat (c)
    begin
      @(posedge clk);
      #1;
      check(rn, 1'b1);
    end
  endtask

  task automatic pulse_sup(input int lo, input int hi);
    @(posedge clk) sup <= 1'b1;
    repeat (lo) @(posedge clk);
    #1 check(rn, 1'b0);
    @(posedge clk) sup <= 1'b0;
    repeat (hi) @(posedge clk);
  endtask

  // second dip inside the hold restarts the full hold
  task automatic t_supply;
    pulse_sup(5, 10);
    #1 check(rn, 1'b0);
    pulse_sup(5, 0);
    wait_lvl(1'b1, n);
    check(n >= HOLD && n <= HOLD + 4, 1'b1);
  endtask

  // bouncing switch: hold runs from the final release
  task automatic t_manual;
    repeat (3)
    begin
      @(posedge clk) mr_n <= 1'b0;
      repeat (4) @(posedge clk);
      mr_n <= 1'b1;
      repeat (4) @(posedge clk);
    end
    #1 check(rn, 1'b0);
    wait_lvl(1'b1, n);
    check(n >= HOLD - 4 && n <= HOLD, 1'b1);
  endtask

  // stalled firmware: expiry counted from release, then a full hold
  task automatic t_dog;
    @(posedge clk) run <= 1'b0;
    mr_n <= 1'b0;
    repeat (4) @(posedge clk);
    mr_n <= 1'b1;
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    check(n >= DOG && n <= DOG + 3, 1'b1);
    wait_lvl(1'b1, n);
    check(n >= HOLD && n <= HOLD + 2, 1'b1);
  endtask

  // floating kick and manual pins never cause a reset
  task automatic t_float;
    @(posedge clk) kick_drv <= 1'b0;
    mr_drv <= 1'b0;
    mr_n <= 1'b0;
    wait_lvl(1'b1, n);
    quiet(3 * DOG);
    check(rn, 1'b1);
  endtask

  initial
  begin
    #50000;
    n_fail++;
    end_sim;
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_lvl(1'b1, n);
    check(n >= HOLD && n <= HOLD + 5, 1'b1);
    quiet(3 * DOG);
    @(posedge clk) pulse <= 1'b1;
    quiet(3 * DOG);
    t_supply;
    t_manual;
    t_dog;
    t_float;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
